// ### core/dcap_cfg.svh
// Contract
// - with wipe guard active, equal non-zero 32-bit keys from both sides start a wipe
// - after a key-started wipe completes, port access returns at the next reset
// - the key lock is write-once and blocks guard removal until reset
// - these registers are reached only from the debug link, never the CPU
// - a wipe command drops the reset request and blocks it until reset
// - wipe command 1 erases flash, SRAM, config area in order; 0 does nothing
// - wipe state reads 1 while wiping, 0 when ready
// - port lock bit 0 shows non-secure protection, 0 enabled, loaded from config
// - port lock bit 1 shows secure protection, 0 enabled, loaded from config
// - wipe guard bit reads 0 when guarded, 1 when wipe allowed, loaded from config
// - debugger write of outbound word sets outbound pending
// - outbound pending reads 1 until the CPU reads the word
// - debugger read of inbound word returns CPU word and clears inbound pending
// - inbound pending reads 1 while a CPU word waits unread
// - a sender write sets its outbound flag and the receiver inbound flag
// - a receiver read clears its inbound flag and the sender outbound flag in the same cycle
// - while locked, the firmware key register ignores writes
`ifndef DCAP_CFG_SVH
`define DCAP_CFG_SVH

// register byte offsets on the debug link
`define DCAP_OFS_RST_REQ 8'h00
`define DCAP_OFS_WIPE_CMD 8'h04
`define DCAP_OFS_WIPE_STATE 8'h08
`define DCAP_OFS_PORT_LOCK 8'h0c
`define DCAP_OFS_GUARD_STATE 8'h18
`define DCAP_OFS_GUARD_KEY 8'h1c
`define DCAP_OFS_OUT_WORD 8'h20
`define DCAP_OFS_OUT_PEND 8'h24
`define DCAP_OFS_IN_WORD 8'h28
`define DCAP_OFS_IN_PEND 8'h2c
`define DCAP_OFS_PORT_ID 8'hfc

// identification field positions
`define DCAP_ID_PORT_LSB 0
`define DCAP_ID_CLASS_LSB 13
`define DCAP_ID_MAKER_LSB 17
`define DCAP_ID_REV_LSB 28

// class codes and reset values
`define DCAP_CLASS_MEM 4'h8
`define DCAP_CLASS_NONE 4'h0
`define DCAP_WORD_RST 32'h0000_0000

`endif

// ### core/dcap_pkg.sv
`default_nettype none
package dcap_pkg;

   // wipe sequencer phases
   typedef enum logic [1:0] {
      DCAP_W_IDLE = 2'b00,
      DCAP_W_FLASH = 2'b01,
      DCAP_W_SRAM = 2'b10,
      DCAP_W_CFG = 2'b11
   } dcap_wipe_t;

   // one register access from the link
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } dcap_req_t;

   // a CPU-side word write strobe
   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } dcap_word_wr_t;

   // configuration words read at reset release
   typedef struct packed {
      logic port_open;
      logic secure_open;
      logic guard_open;
   } dcap_cfg_word_t;

   // link-domain state
   typedef struct packed {
      dcap_req_t req;
      logic req_tgl;
      logic ack_s1;
      logic ack_s2;
      logic ack_seen;
      logic busy;
      logic ack;
      logic [31:0] rdata;
   } dcap_link_st_t;

   // system-domain state
   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_seen;
      logic ack_tgl;
      logic [31:0] rsp_data;
      logic rst_req;
      logic rst_block;
      dcap_wipe_t wipe;
      logic wipe_restore;
      logic cfg_loaded;
      dcap_cfg_word_t open;
      logic [31:0] dbg_key;
      logic dbg_key_wr;
      logic [31:0] cpu_key;
      logic cpu_key_wr;
      logic lock;
      logic key_fired;
      logic [31:0] out_word;
      logic out_pend;
      logic [31:0] in_word;
      logic in_pend;
   } dcap_sys_st_t;

endpackage
`default_nettype wire

// ### core/dcap_link.sv
`include "dcap_cfg.svh"
`default_nettype none
module dcap_link (
   // link clock and reset
   input wire logic link_clk_i,
   input wire logic sys_rst_i,
   // access from the link decoder
   input wire logic lk_req_i,
   input wire dcap_pkg::dcap_req_t lk_cmd_i,
   output logic [31:0] lk_rdata_o,
   output logic lk_ack_o,
   output logic lk_busy_o,
   // crossing to the system domain
   output dcap_pkg::dcap_req_t x_req_o,
   output logic x_req_tgl_o,
   input wire logic x_ack_tgl_i,
   input wire logic [31:0] x_rsp_data_i
);
   import dcap_pkg::*;

   dcap_link_st_t st_r;
   dcap_link_st_t st_nxt;

   // accept one access at a time, finish it on the synchronised ack toggle
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.ack_s1 = x_ack_tgl_i;
      st_nxt.ack_s2 = st_r.ack_s1;
      if (st_r.ack_s2 != st_r.ack_seen) begin
         st_nxt.ack_seen = st_r.ack_s2;
         st_nxt.rdata = x_rsp_data_i; // registered on the same edge as the toggle, stable since then
         st_nxt.ack = 1'b1;
         st_nxt.busy = 1'b0;
      end else if (lk_req_i && !st_r.busy) begin
         st_nxt.req = lk_cmd_i; // held until the answer returns
         st_nxt.req_tgl = ~st_r.req_tgl;
         st_nxt.busy = 1'b1;
      end
   end

   // link-domain registers
   always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lk_rdata_o = st_r.rdata;
   assign lk_ack_o = st_r.ack;
   assign lk_busy_o = st_r.busy;
   assign x_req_o = st_r.req;
   assign x_req_tgl_o = st_r.req_tgl;
endmodule
`default_nettype wire

// ### core/dcap_top.sv
`include "dcap_cfg.svh"
`default_nettype none
module dcap_top #(
   parameter logic [7:0] PORT_ID = 8'h00,
   parameter logic [3:0] PORT_CLASS = 4'h0,
   parameter logic [10:0] MAKER_ID = 11'h2a5, // arbitrary value
   parameter logic [3:0] PORT_REV = 4'h1 // arbitrary value
) (
   // system clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // debug link side
   input wire logic link_clk_i,
   input wire logic lk_req_i,
   input wire dcap_pkg::dcap_req_t lk_cmd_i,
   output logic [31:0] lk_rdata_o,
   output logic lk_ack_o,
   output logic lk_busy_o,
   // configuration words at reset release
   input wire dcap_pkg::dcap_cfg_word_t cfg_word_i,
   // wipe engine
   input wire logic wipe_step_done_i,
   output dcap_pkg::dcap_wipe_t wipe_phase_o,
   output logic wipe_restore_o,
   // reset and protection status
   output logic sys_reset_req_o,
   output logic port_open_o,
   output logic secure_open_o,
   output logic guard_open_o,
   // firmware side of the mailbox and key
   input wire dcap_pkg::dcap_word_wr_t cpu_out_wr_i,
   input wire logic cpu_in_rd_i,
   input wire dcap_pkg::dcap_word_wr_t cpu_key_wr_i,
   input wire logic cpu_lock_wr_i,
   output logic [31:0] cpu_in_word_o,
   output logic cpu_in_pend_o,
   output logic cpu_out_pend_o,
   output logic [31:0] cpu_key_o,
   output logic cpu_lock_o
);
   import dcap_pkg::*;

   // refuse class codes other than the two defined ones
   if (PORT_CLASS != `DCAP_CLASS_MEM && PORT_CLASS != `DCAP_CLASS_NONE) begin : g_chk
      $error("dcap_top: PORT_CLASS must be 0x0 or 0x8");
   end

   dcap_sys_st_t st_r;
   dcap_sys_st_t st_nxt;
   dcap_req_t x_req;
   logic x_req_tgl;
   logic [31:0] id_word;

   // identification word built from parameters
   assign id_word = (32'(PORT_ID) << `DCAP_ID_PORT_LSB)
      | (32'(PORT_CLASS) << `DCAP_ID_CLASS_LSB)
      | (32'(MAKER_ID) << `DCAP_ID_MAKER_LSB)
      | (32'(PORT_REV) << `DCAP_ID_REV_LSB);

   // link-side half of the access crossing
   dcap_link u_link (
      .link_clk_i(link_clk_i),
      .sys_rst_i(sys_rst_i),
      .lk_req_i(lk_req_i),
      .lk_cmd_i(lk_cmd_i),
      .lk_rdata_o(lk_rdata_o),
      .lk_ack_o(lk_ack_o),
      .lk_busy_o(lk_busy_o),
      .x_req_o(x_req),
      .x_req_tgl_o(x_req_tgl),
      .x_ack_tgl_i(st_r.ack_tgl),
      .x_rsp_data_i(st_r.rsp_data)
   );

   // read value of one register, zero for unmapped offsets
   function automatic logic [31:0] reg_read(input dcap_sys_st_t s, input logic [7:0] addr,
                                           input logic [31:0] idw);
      logic [31:0] v;
      v = `DCAP_WORD_RST;
      case (addr)
         `DCAP_OFS_RST_REQ: v[0] = s.rst_req;
         `DCAP_OFS_WIPE_STATE: v[0] = (s.wipe != DCAP_W_IDLE);
         `DCAP_OFS_PORT_LOCK: v[1:0] = {s.open.secure_open, s.open.port_open};
         `DCAP_OFS_GUARD_STATE: v[0] = s.open.guard_open;
         `DCAP_OFS_GUARD_KEY: v = s.dbg_key;
         `DCAP_OFS_OUT_WORD: v = s.out_word;
         `DCAP_OFS_OUT_PEND: v[0] = s.out_pend;
         `DCAP_OFS_IN_WORD: v = s.in_word;
         `DCAP_OFS_IN_PEND: v[0] = s.in_pend;
         `DCAP_OFS_PORT_ID: v = idw;
         default: v = `DCAP_WORD_RST;
      endcase
      return v;
   endfunction

   // both keys written, equal and non-zero
   function automatic logic keys_agree(input dcap_sys_st_t s);
      return s.dbg_key_wr && s.cpu_key_wr && (s.dbg_key == s.cpu_key)
         && (s.dbg_key != `DCAP_WORD_RST);
   endfunction

   // wipe phase that follows a finished one
   function automatic dcap_wipe_t next_phase(input dcap_wipe_t w);
      dcap_wipe_t n;
      n = DCAP_W_IDLE;
      case (w)
         DCAP_W_FLASH: n = DCAP_W_SRAM;
         DCAP_W_SRAM: n = DCAP_W_CFG;
         DCAP_W_CFG: n = DCAP_W_IDLE;
         default: n = DCAP_W_IDLE;
      endcase
      return n;
   endfunction

   // next state of the whole register set
   always_comb begin
      logic acc;
      logic start_wipe;
      logic dbg_in_rd;
      logic dbg_out_wr;
      acc = 1'b0;
      start_wipe = 1'b0;
      dbg_in_rd = 1'b0;
      dbg_out_wr = 1'b0;
      st_nxt = st_r;

      // request toggle crossing into this domain
      st_nxt.req_s1 = x_req_tgl;
      st_nxt.req_s2 = st_r.req_s1;
      acc = (st_r.req_s2 != st_r.req_seen);

      // configuration words caught once after reset release
      if (!st_r.cfg_loaded) begin
         st_nxt.cfg_loaded = 1'b1;
         st_nxt.open = cfg_word_i;
      end

      // only link accesses reach the register set
      if (acc) begin
         st_nxt.req_seen = st_r.req_s2;
         st_nxt.ack_tgl = ~st_r.ack_tgl;
         st_nxt.rsp_data = x_req.wr ? `DCAP_WORD_RST : reg_read(st_r, x_req.addr, id_word);
         if (x_req.wr) begin
            case (x_req.addr)
               `DCAP_OFS_RST_REQ: begin
                  if (!st_r.rst_block) begin
                     st_nxt.rst_req = x_req.wdata[0];
                  end
               end
               `DCAP_OFS_WIPE_CMD: begin
                  // a zero write, a guarded device or a running wipe does nothing
                  if (x_req.wdata[0] && st_r.open.guard_open && st_r.wipe == DCAP_W_IDLE) begin
                     start_wipe = 1'b1;
                  end
               end
               `DCAP_OFS_GUARD_KEY: begin
                  st_nxt.dbg_key = x_req.wdata;
                  st_nxt.dbg_key_wr = 1'b1;
               end
               `DCAP_OFS_OUT_WORD: begin
                  st_nxt.out_word = x_req.wdata;
                  dbg_out_wr = 1'b1;
               end
               default: begin
               end
            endcase
         end else if (x_req.addr == `DCAP_OFS_IN_WORD) begin
            dbg_in_rd = 1'b1;
         end
      end

      // firmware lock is write-once until reset
      if (cpu_lock_wr_i) begin
         st_nxt.lock = 1'b1;
      end

      // firmware key, ignored while locked
      if (cpu_key_wr_i.valid && !st_r.lock) begin
         st_nxt.cpu_key = cpu_key_wr_i.data;
         st_nxt.cpu_key_wr = 1'b1;
      end

      // matching keys lift the guard and start the wipe once
      if (!st_r.open.guard_open && !st_r.lock && !st_r.key_fired && keys_agree(st_r)
          && st_r.wipe == DCAP_W_IDLE) begin
         st_nxt.open.guard_open = 1'b1;
         st_nxt.key_fired = 1'b1;
         start_wipe = 1'b1;
      end

      // wipe sequencer: flash, then SRAM, then config area
      if (start_wipe) begin
         st_nxt.wipe = DCAP_W_FLASH;
         st_nxt.rst_req = 1'b0;
         st_nxt.rst_block = 1'b1;
      end else if (st_r.wipe != DCAP_W_IDLE && wipe_step_done_i) begin
         st_nxt.wipe = next_phase(st_r.wipe);
         if (st_r.wipe == DCAP_W_CFG) begin
            st_nxt.wipe_restore = 1'b1;
         end
      end

      // debugger to CPU word: debugger write sets, CPU read clears, set wins
      if (dbg_out_wr) begin
         st_nxt.out_pend = 1'b1;
      end else if (cpu_in_rd_i) begin
         st_nxt.out_pend = 1'b0;
      end

      // CPU to debugger word: CPU write sets, debugger read clears, set wins
      if (cpu_out_wr_i.valid) begin
         st_nxt.in_word = cpu_out_wr_i.data;
         st_nxt.in_pend = 1'b1;
      end else if (dbg_in_rd) begin
         st_nxt.in_pend = 1'b0;
      end
   end

   // system-domain registers
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from state flops
   assign wipe_phase_o = st_r.wipe;
   assign wipe_restore_o = st_r.wipe_restore;
   assign sys_reset_req_o = st_r.rst_req;
   assign port_open_o = st_r.open.port_open;
   assign secure_open_o = st_r.open.secure_open;
   assign guard_open_o = st_r.open.guard_open;
   assign cpu_in_word_o = st_r.out_word;
   assign cpu_in_pend_o = st_r.out_pend;
   assign cpu_out_pend_o = st_r.in_pend;
   assign cpu_key_o = st_r.cpu_key;
   assign cpu_lock_o = st_r.lock;
endmodule
`default_nettype wire

// ### testbench/dcap_chk_checker.sv
`default_nettype none
module dcap_chk (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // wipe and reset request
   input wire logic wipe_step_done_i,
   input wire dcap_pkg::dcap_wipe_t wipe_phase_o,
   input wire logic wipe_restore_o,
   input wire logic sys_reset_req_o,
   // firmware side
   input wire dcap_pkg::dcap_word_wr_t cpu_out_wr_i,
   input wire logic cpu_out_pend_o,
   input wire dcap_pkg::dcap_word_wr_t cpu_key_wr_i,
   input wire logic [31:0] cpu_key_o,
   input wire logic cpu_lock_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import dcap_pkg::*;
   // everything here lives on the system clock
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);
   flash_sram_a: assert property (wipe_phase_o == DCAP_W_FLASH && wipe_step_done_i
      |=> wipe_phase_o == DCAP_W_SRAM) else $error("flash phase not followed by sram");
   sram_cfg_a: assert property (wipe_phase_o == DCAP_W_SRAM && wipe_step_done_i
      |=> wipe_phase_o == DCAP_W_CFG) else $error("sram phase not followed by config");
   cfg_done_a: assert property (wipe_phase_o == DCAP_W_CFG && wipe_step_done_i
      |=> wipe_phase_o == DCAP_W_IDLE && wipe_restore_o) else $error("wipe end wrong");
   busy_no_rst_a: assert property (wipe_phase_o != DCAP_W_IDLE |-> !sys_reset_req_o)
      else $error("reset request during wipe");
   restore_keep_a: assert property (wipe_restore_o |=> wipe_restore_o && !sys_reset_req_o)
      else $error("restore flag or reset block lost");
   lock_keep_a: assert property (cpu_lock_o |=> cpu_lock_o)
      else $error("key lock released");
   key_frozen_a: assert property (cpu_lock_o && cpu_key_wr_i.valid |=> $stable(cpu_key_o))
      else $error("locked key changed");
   out_pend_a: assert property (cpu_out_wr_i.valid |=> cpu_out_pend_o)
      else $error("cpu word not pending");
endmodule
bind dcap_top dcap_chk i_dcap_chk (.clk_sys_i, .sys_rst_i, .wipe_step_done_i, .wipe_phase_o,
   .wipe_restore_o, .sys_reset_req_o, .cpu_out_wr_i, .cpu_out_pend_o, .cpu_key_wr_i,
   .cpu_key_o, .cpu_lock_o);
`default_nettype wire

// ### testbench/dcap_probe.sv
`default_nettype none
module dcap_probe (
   // reset and link clock
   input wire logic rst_i,
   output logic link_clk_o,
   // register link
   output logic lk_req_o,
   output dcap_pkg::dcap_req_t lk_cmd_o,
   input wire logic [31:0] lk_rdata_i,
   input wire logic lk_ack_i,
   input wire logic lk_busy_i
);
   timeunit 1ns;
   timeprecision 100ps;
   import dcap_pkg::*;
   logic run;
   // link clock only runs inside a frame or while reset is held
   initial begin
      link_clk_o = 1'b0;
      #1.7;
      forever begin
         #6;
         link_clk_o = (run || rst_i) ? ~link_clk_o : 1'b0;
      end
   end
   // idle link
   initial begin
      run = 1'b0;
      lk_req_o = 1'b0;
      lk_cmd_o = '0;
   end
   // one access, held until taken, answer taken at the ack
   task automatic access(input logic w, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic ok);
      logic b;
      logic got;
      ok = 1'b0;
      got = 1'b0;
      rd = 32'h0;
      run = 1'b1;
      @(posedge link_clk_o);
      #1;
      lk_req_o = 1'b1;
      lk_cmd_o = '{wr: w, addr: a, wdata: wd};
      for (int n = 0; n < 40 && !ok; n++) begin
         @(negedge link_clk_o);
         b = lk_busy_i;
         @(posedge link_clk_o);
         ok = (b === 1'b0);
      end
      #1;
      lk_req_o = 1'b0;
      lk_cmd_o = ~lk_cmd_o;
      for (int n = 0; n < 40 && ok && !got; n++) begin
         @(negedge link_clk_o);
         if (lk_ack_i === 1'b1) begin
            got = 1'b1;
            rd = lk_rdata_i;
         end
      end
      ok = got;
      run = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import dcap_pkg::*;
   localparam logic [7:0] PID = 8'h3c;
   localparam logic [3:0] PCLS = 4'h8;
   localparam logic [31:0] ID_EXP = {4'h1, 11'h2a5, PCLS, 5'h00, PID};
   logic clk_sys_i, sys_rst_i, step, in_rd, lock_wr, lclk, lreq, lack, lbusy;
   logic restore, rreq, popen, sopen, gopen, in_pend, out_pend, lock_o;
   logic [31:0] lrd, in_word, key_o;
   dcap_req_t lcmd;
   dcap_cfg_word_t cfg;
   dcap_word_wr_t out_wr, key_wr;
   dcap_wipe_t phase;
   int cmp_count = 0;
   int miscompares = 0;
   dcap_top #(.PORT_ID(PID), .PORT_CLASS(PCLS)) i_dcap_top (.clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i), .link_clk_i(lclk), .lk_req_i(lreq), .lk_cmd_i(lcmd),
      .lk_rdata_o(lrd), .lk_ack_o(lack), .lk_busy_o(lbusy), .cfg_word_i(cfg),
      .wipe_step_done_i(step), .wipe_phase_o(phase), .wipe_restore_o(restore),
      .sys_reset_req_o(rreq), .port_open_o(popen), .secure_open_o(sopen), .guard_open_o(gopen),
      .cpu_out_wr_i(out_wr), .cpu_in_rd_i(in_rd), .cpu_key_wr_i(key_wr), .cpu_lock_wr_i(lock_wr),
      .cpu_in_word_o(in_word), .cpu_in_pend_o(in_pend), .cpu_out_pend_o(out_pend),
      .cpu_key_o(key_o), .cpu_lock_o(lock_o));
   dcap_probe i_dcap_probe (.rst_i(sys_rst_i), .link_clk_o(lclk), .lk_req_o(lreq),
      .lk_cmd_o(lcmd), .lk_rdata_i(lrd), .lk_ack_i(lack), .lk_busy_i(lbusy));
   // system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   // verdict and end of run
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // link accesses through the probe
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      logic ok;
      i_dcap_probe.access(w, a, d, r, ok);
      if (ok !== 1'b1) begin
         miscompares++;
         $display("Error at %0t: link access timed out", $time);
         test_done();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      acc(1'b1, a, d, r);
      @(negedge clk_sys_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      acc(1'b0, a, 32'h0, r);
      chk(r, e);
      // back onto the system clock's falling edge before the next strobe
      @(negedge clk_sys_i);
   endtask
   // firmware key write, then two cycles for the match
   task automatic cpu_key(input logic [31:0] k);
      key_wr = '{valid: 1'b1, data: k};
      @(negedge clk_sys_i);
      key_wr = '{valid: 1'b0, data: 32'h0};
      repeat (2) @(negedge clk_sys_i);
   endtask
   task automatic stp(input dcap_wipe_t e);
      step = 1'b1;
      @(negedge clk_sys_i);
      step = 1'b0;
      @(negedge clk_sys_i);
      chk({30'h0, phase}, {30'h0, e});
   endtask
   task automatic do_reset();
      sys_rst_i = 1'b1;
      repeat (10) @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
   endtask
   task automatic t_status();
      rd(8'h00, 32'h0);
      wr(8'h08, 32'h1);
      rd(8'h08, 32'h0);
      rd(8'h0c, 32'h1);
      rd(8'h18, 32'h0);
      rd(8'h40, 32'h0);
      rd(8'hfc, ID_EXP);
      chk({29'h0, popen, sopen, gopen}, 32'h4);
      $display("t_status done");
   endtask
   task automatic t_mbox();
      wr(8'h20, 32'hc0de_0001);
      chk({31'h0, in_pend}, 32'h1);
      chk(in_word, 32'hc0de_0001);
      rd(8'h24, 32'h1);
      in_rd = 1'b1;
      @(negedge clk_sys_i);
      in_rd = 1'b0;
      @(negedge clk_sys_i);
      rd(8'h24, 32'h0);
      out_wr = '{valid: 1'b1, data: 32'h5eed_0002};
      @(negedge clk_sys_i);
      out_wr = '{valid: 1'b0, data: 32'h0};
      rd(8'h2c, 32'h1);
      rd(8'h28, 32'h5eed_0002);
      rd(8'h2c, 32'h0);
      chk({31'h0, out_pend}, 32'h0);
      $display("t_mbox done");
   endtask
   task automatic t_keys();
      wr(8'h00, 32'h1);
      rd(8'h00, 32'h1);
      wr(8'h00, 32'h0);
      chk({31'h0, rreq}, 32'h0);
      wr(8'h00, 32'h1);
      wr(8'h04, 32'h1);
      wr(8'h1c, 32'h0000_5a5a);
      rd(8'h1c, 32'h0000_5a5a);
      cpu_key(32'h0000_5a5b);
      chk({29'h0, gopen, phase}, 32'h0);
      wr(8'h1c, 32'h0);
      cpu_key(32'h0);
      chk({29'h0, gopen, phase}, 32'h0);
      wr(8'h1c, 32'h600d_f00d);
      cpu_key(32'h600d_f00d);
      chk({28'h0, gopen, rreq, phase}, {28'h0, 1'b1, 1'b0, DCAP_W_FLASH});
      rd(8'h08, 32'h1);
      wr(8'h00, 32'h1);
      rd(8'h00, 32'h0);
      stp(DCAP_W_SRAM);
      stp(DCAP_W_CFG);
      stp(DCAP_W_IDLE);
      chk({31'h0, restore}, 32'h1);
      rd(8'h08, 32'h0);
      wr(8'h04, 32'h0);
      chk({30'h0, phase}, 32'h0);
      wr(8'h04, 32'h1);
      chk({29'h0, rreq, phase}, 32'h1);
      stp(DCAP_W_SRAM);
      stp(DCAP_W_CFG);
      stp(DCAP_W_IDLE);
      $display("t_keys done");
   endtask
   task automatic t_lock();
      cfg = '{port_open: 1'b1, secure_open: 1'b1, guard_open: 1'b1};
      do_reset();
      rd(8'h0c, 32'h3);
      rd(8'h18, 32'h1);
      cfg = '{port_open: 1'b0, secure_open: 1'b0, guard_open: 1'b0};
      do_reset();
      cpu_key(32'h2468_ace0);
      lock_wr = 1'b1;
      @(negedge clk_sys_i);
      lock_wr = 1'b0;
      @(negedge clk_sys_i);
      chk({31'h0, lock_o}, 32'h1);
      cpu_key(32'h1357_9bdf);
      chk(key_o, 32'h2468_ace0);
      wr(8'h1c, 32'h2468_ace0);
      chk({29'h0, gopen, phase}, 32'h0);
      rd(8'h18, 32'h0);
      $display("t_lock done");
   endtask
   // main sequence
   initial begin
      sys_rst_i = 1'b1;
      step = 1'b0;
      in_rd = 1'b0;
      lock_wr = 1'b0;
      out_wr = '0;
      key_wr = '0;
      cfg = '{port_open: 1'b1, secure_open: 1'b0, guard_open: 1'b0};
      do_reset();
      t_status();
      t_mbox();
      t_keys();
      t_lock();
      test_done();
   end
endmodule
`default_nettype wire
